// [design/spmsp_top.sv]
/*
 * Serial port that acts as bus master or slave, 3-wire or 4-wire, with APB registers.
 * Assumes pclk at 125 MHz, sck_in as the slave link clock and an outside pad ring that
 * resolves the pin enables; all pin inputs except sck_in are asynchronous.
 */
// How it works
// - mosi out as master, input as slave, msb first
// - master drives mosi from shift register msb
// - miso sampled as master, driven as slave
// - miso floats when disabled or unselected slave
// - 3-wire slave drives miso from msb always
// - master makes sck, slave takes it in
// - unselected 4-wire slave ignores sck
// - mode 00 is 3-wire, slave always selected
// - mode 01 is 4-wire, select input selects
// - mode 01 master falling select drops master
// - mode 1x drives select out at low bit
// - select pin mapped unless mode 00
// - master data write loads and starts transfer
// - done flag set each byte, sticky
// - mode fault clears enables, sets fault flag
// - select fall clears bit counter, eight bits
`timescale 1ns/1ps
`include "spmsp_defs.svh"

module spmsp_top #(
	parameter int SCK_HALF = `SPMSP_SCK_HALF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic sck_in,
	input wire spmsp_pkg::spmsp_pin_in_type pin_in,
	output spmsp_pkg::spmsp_pin_out_type pin_out,
	output logic miso_out
);
	import spmsp_pkg::*;

	// ==========================================================
	// checks and helpers
	// below 2 the miso synchroniser lags a half period; above 37 a byte outruns a_byte_len
	if (SCK_HALF < 2 || SCK_HALF > 37) begin : g_chk
		$error("SCK_HALF must lie in 2..37");
	end

	function automatic logic f_selected(input logic [1:0] smode, input logic nss);
		f_selected = (smode == `SPMSP_SM_3WIRE) || (smode == `SPMSP_SM_4WIN && !nss);
	endfunction

	spmsp_pstate_type st, next_st;
	spmsp_sstate_type ss, next_ss;
	logic slv_rst_n;
	logic [7:0] slv_src;
	logic [7:0] slv_rx;
	logic slv_tog;
	logic acc;
	logic setup;

	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign prdata = st.prdata;
	assign pin_out = st.pins;

	// ==========================================================
	// slave link domain
	// the slave shifter is held in reset while not selected, so sck edges are dropped
	// and a select fall starts a fresh byte; enables are quasi-static config
	assign slv_rst_n = presetn && st.port_en && !st.master_en && f_selected(st.smode, pin_in.nss_in);
	// byte start takes the transmit buffer, which software must not rewrite mid-byte
	assign slv_src = (ss.cnt == 3'h0) ? (st.tx_full ? st.tx_buf : `SPMSP_IDLE_TX) : ss.sh;
	// msb leads before the first edge, so miso is a mux here, not a flop
	assign miso_out = slv_src[7];

	always_comb begin
		next_ss = ss;
		next_ss.sh = {slv_src[6:0], pin_in.mosi_in};
		next_ss.cnt = ss.cnt + 3'h1;
	end

	always_ff @(posedge sck_in or negedge slv_rst_n) begin
		if (!slv_rst_n) begin
			ss.sh <= 8'h00;
			ss.cnt <= 3'h0;
		end else begin
			ss <= next_ss;
		end
	end

	// finished byte and its toggle live outside the select reset, so a deselect
	// right after the eighth edge cannot wipe the byte before pclk has taken it
	always_ff @(posedge sck_in or negedge presetn) begin
		if (!presetn) begin
			slv_rx <= 8'h00;
			slv_tog <= 1'b0;
		end else if (ss.cnt == 3'h7) begin
			slv_rx <= {slv_src[6:0], pin_in.mosi_in};
			slv_tog <= !slv_tog;
		end
	end

	// ==========================================================
	// system clock domain
	assign setup = psel && penable && !st.pready;
	assign acc = psel && penable && st.pready;

	always_comb begin
		next_st = st;
		// pin synchronisers
		next_st.miso_s1 = pin_in.miso_in;
		next_st.miso_s2 = st.miso_s1;
		next_st.nss_s1 = pin_in.nss_in;
		next_st.nss_s2 = st.nss_s1;
		next_st.nss_s3 = st.nss_s2;
		// rx toggle is safe to follow: rx word stays put for eight sck edges
		next_st.tog_s1 = slv_tog;
		next_st.tog_s2 = st.tog_s1;
		next_st.tog_s3 = st.tog_s2;

		// apb answer one cycle into the access phase
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		next_st.prdata = 32'h0000_0000;
		if (setup) begin
			case (paddr)
				`SPMSP_CTRL_OFF: begin
					next_st.prdata[`SPMSP_CTRL_PEN] = st.port_en;
					next_st.prdata[`SPMSP_CTRL_MEN] = st.master_en;
					next_st.prdata[`SPMSP_CTRL_SMHI:`SPMSP_CTRL_SMLO] = st.smode;
				end
				`SPMSP_STAT_OFF: begin
					next_st.prdata[`SPMSP_STAT_DONE] = st.done;
					next_st.prdata[`SPMSP_STAT_WCOL] = st.wcol;
					next_st.prdata[`SPMSP_STAT_MODE_FAULT_FLAG] = st.mode_fault_flag;
					next_st.prdata[`SPMSP_STAT_RXOVR] = st.rxovr;
					next_st.prdata[`SPMSP_STAT_TXFULL] = st.tx_full;
					next_st.prdata[`SPMSP_STAT_BUSY] = (st.mst != M_IDLE);
				end
				`SPMSP_DATA_OFF: begin
					if (!pwrite) begin
						next_st.prdata[7:0] = st.rx_buf;
					end
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end
		if (acc) begin
			case (paddr)
				`SPMSP_CTRL_OFF: begin
					if (pwrite) begin
						next_st.port_en = pwdata[`SPMSP_CTRL_PEN];
						next_st.master_en = pwdata[`SPMSP_CTRL_MEN];
						next_st.smode = pwdata[`SPMSP_CTRL_SMHI:`SPMSP_CTRL_SMLO];
					end
				end
				`SPMSP_STAT_OFF: begin
					if (pwrite) begin
						next_st.done = st.done && !pwdata[`SPMSP_STAT_DONE];
						next_st.wcol = st.wcol && !pwdata[`SPMSP_STAT_WCOL];
						next_st.mode_fault_flag = st.mode_fault_flag && !pwdata[`SPMSP_STAT_MODE_FAULT_FLAG];
						next_st.rxovr = st.rxovr && !pwdata[`SPMSP_STAT_RXOVR];
					end
				end
				`SPMSP_DATA_OFF: begin
					if (pwrite) begin
						if (st.tx_full) begin
							next_st.wcol = 1'b1;
						end else begin
							next_st.tx_buf = pwdata[7:0];
							next_st.tx_full = 1'b1;
						end
					end else begin
						next_st.rx_unread = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// hardware events come after software clears, so a set wins
		if (st.tog_s2 != st.tog_s3) begin
			next_st.done = 1'b1;
			next_st.tx_full = 1'b0;
			if (st.rx_unread && !(acc && !pwrite && paddr == `SPMSP_DATA_OFF)) begin
				next_st.rxovr = 1'b1;
			end else begin
				next_st.rx_buf = slv_rx;
				next_st.rx_unread = 1'b1;
			end
		end

		// multi-master: a select fall while master hands the bus over
		if (st.smode == `SPMSP_SM_4WIN && st.master_en && st.port_en && st.nss_s3 && !st.nss_s2) begin
			next_st.master_en = 1'b0;
			next_st.port_en = 1'b0;
			next_st.mode_fault_flag = 1'b1;
		end

		// master sequencer, mode 0: sck rises mid-bit, the bit is taken and shifted at the fall;
		// at the rise the synchroniser may still show the bit from before the last fall
		case (st.mst)
			M_IDLE: begin
				next_st.pins.sck_out = 1'b0;
				if (st.master_en && st.port_en && st.tx_full) begin
					next_st.sh = st.tx_buf;
					next_st.tx_full = 1'b0;
					next_st.div = 8'h00;
					next_st.bitn = 3'h0;
					next_st.mst = M_LOW;
				end
			end
			M_LOW: begin
				next_st.div = st.div + 8'h01;
				if (st.div == 8'(SCK_HALF - 1)) begin
					next_st.div = 8'h00;
					next_st.pins.sck_out = 1'b1;
					next_st.mst = M_HIGH;
				end
			end
			M_HIGH: begin
				next_st.div = st.div + 8'h01;
				if (st.div == 8'(SCK_HALF - 1)) begin
					next_st.div = 8'h00;
					next_st.pins.sck_out = 1'b0;
					next_st.sh = {st.sh[6:0], st.miso_s2};
					next_st.bitn = st.bitn + 3'h1;
					next_st.mst = M_LOW;
					if (st.bitn == 3'h7) begin
						next_st.rx_buf = {st.sh[6:0], st.miso_s2};
						next_st.rx_unread = 1'b1;
						next_st.done = 1'b1;
						next_st.mst = M_IDLE;
					end
				end
			end
			default: begin
				next_st.mst = M_IDLE;
			end
		endcase
		// dropping either enable abandons a byte in flight
		if (!next_st.master_en || !next_st.port_en) begin
			next_st.mst = M_IDLE;
			next_st.pins.sck_out = 1'b0;
		end

		// pin directions follow the next configuration
		next_st.pins.mosi_out = next_st.sh[7];
		next_st.pins.mosi_oe_n = !(next_st.port_en && next_st.master_en);
		next_st.pins.sck_oe_n = !(next_st.port_en && next_st.master_en);
		next_st.pins.miso_oe_n = !(next_st.port_en && !next_st.master_en
			&& f_selected(next_st.smode, st.nss_s2));
		next_st.pins.nss_out = next_st.smode[0];
		next_st.pins.nss_oe_n = !(next_st.port_en && next_st.smode[1]);
		next_st.pins.nss_mapped = (next_st.smode != `SPMSP_SM_3WIRE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.smode <= 2'(`SPMSP_CTRL_RST >> `SPMSP_CTRL_SMLO);
			st.mst <= M_IDLE;
			st.pins.mosi_oe_n <= 1'b1;
			st.pins.miso_oe_n <= 1'b1;
			st.pins.sck_oe_n <= 1'b1;
			st.pins.nss_oe_n <= 1'b1;
			st.pins.nss_out <= 1'b1;
			st.pins.nss_mapped <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// assertions
	property p_mosi_dir;
		@(posedge pclk) disable iff (!presetn)
		(st.port_en && st.master_en) |=> pin_out.mosi_oe_n == !(st.port_en && st.master_en);
	endproperty
	a_mosi_dir: assert property (p_mosi_dir) else $error("mosi not driven as master");

	property p_mosi_msb;
		@(posedge pclk) disable iff (!presetn)
		(st.mst == M_HIGH && next_st.mst == M_LOW) |=> pin_out.mosi_out == $past(st.sh[6]);
	endproperty
	a_mosi_msb: assert property (p_mosi_msb) else $error("mosi not from shifter msb");

	property p_miso_hiz;
		@(posedge pclk) disable iff (!presetn)
		(!st.port_en || st.master_en) [*2] |-> pin_out.miso_oe_n;
	endproperty
	a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while disabled");

	property p_sck_gen;
		@(posedge pclk) disable iff (!presetn)
		(st.mst == M_LOW && next_st.mst == M_HIGH) |=> pin_out.sck_out && !pin_out.sck_oe_n;
	endproperty
	a_sck_gen: assert property (p_sck_gen) else $error("master sck not generated");

	property p_mode_fault_flag;
		@(posedge pclk) disable iff (!presetn)
		(st.smode == 2'h1 && st.master_en && st.port_en && st.nss_s3 && !st.nss_s2)
			|=> st.mode_fault_flag && !st.master_en && !st.port_en ##1 pin_out.mosi_oe_n;
	endproperty
	a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not taken");

	property p_done_sticky;
		@(posedge pclk) disable iff (!presetn)
		st.done && !(acc && pwrite && paddr == 12'h004) |=> st.done;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

	property p_nss_out;
		@(posedge pclk) disable iff (!presetn)
		(st.port_en && st.smode[1]) [*2] |-> !pin_out.nss_oe_n && pin_out.nss_out == st.smode[0];
	endproperty
	a_nss_out: assert property (p_nss_out) else $error("select output level wrong");

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		(st.mst == M_IDLE && st.tx_full && st.master_en && st.port_en && next_st.master_en && next_st.port_en)
			|=> st.mst == M_LOW && !st.tx_full;
	endproperty
	a_start: assert property (p_start) else $error("master transfer did not start");

	property p_byte_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(st.mst == M_LOW) && st.bitn == 3'h0 |-> ##[1:600] (st.mst == M_IDLE);
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("master byte too long");

	property p_pinmap;
		@(posedge pclk) disable iff (!presetn)
		$changed(st.smode) |-> pin_out.nss_mapped == (st.smode != 2'h0);
	endproperty
	a_pinmap: assert property (p_pinmap) else $error("select pin mapping wrong");

endmodule

// [shared/spmsp_defs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the serial port.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
`ifndef SPMSP_DEFS_SVH
`define SPMSP_DEFS_SVH

// ==========================================================
// register offsets (byte addresses)
`define SPMSP_CTRL_OFF 12'h000
`define SPMSP_STAT_OFF 12'h004
`define SPMSP_DATA_OFF 12'h008

// ==========================================================
// port_control_reg fields
`define SPMSP_CTRL_PEN 0
`define SPMSP_CTRL_MEN 1
`define SPMSP_CTRL_SMLO 2
`define SPMSP_CTRL_SMHI 3
// select_mode 01 after reset: 4-wire slave / multi-master
`define SPMSP_CTRL_RST 4'h4

// ==========================================================
// status fields, write one to clear the sticky ones
`define SPMSP_STAT_BUSY 0
`define SPMSP_STAT_TXFULL 1
`define SPMSP_STAT_RXOVR 4
`define SPMSP_STAT_MODE_FAULT_FLAG 5
`define SPMSP_STAT_WCOL 6
`define SPMSP_STAT_DONE 7

// ==========================================================
// select_mode encodings
`define SPMSP_SM_3WIRE 2'h0
`define SPMSP_SM_4WIN 2'h1

// ==========================================================
// master serial clock: half period in pclk cycles
`define SPMSP_SCK_HALF 2
`define SPMSP_BITS 8
`define SPMSP_IDLE_TX 8'hFF

`endif

// [shared/spmsp_pkg.sv]
/*
 * Types of the serial port: master states, pin groups and the state records of both clock domains.
 * Assumes the constants of spmsp_defs.svh for offsets and fields.
 */
package spmsp_pkg;

	// ==========================================================
	// master sequencer
	typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} spmsp_mstate_type;

	// ==========================================================
	// pin groups
	typedef struct packed {
		logic mosi_in;
		logic miso_in;
		logic nss_in;
	} spmsp_pin_in_type;

	typedef struct packed {
		logic mosi_out;
		logic mosi_oe_n;
		logic miso_oe_n;
		logic sck_out;
		logic sck_oe_n;
		logic nss_out;
		logic nss_oe_n;
		logic nss_mapped;
	} spmsp_pin_out_type;

	// ==========================================================
	// pclk domain state
	typedef struct packed {
		logic port_en;
		logic master_en;
		logic [1:0] smode;
		logic done;
		logic wcol;
		logic mode_fault_flag;
		logic rxovr;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] rx_buf;
		logic rx_unread;
		logic [7:0] sh;
		spmsp_mstate_type mst;
		logic [7:0] div;
		logic [2:0] bitn;
		logic miso_s1;
		logic miso_s2;
		logic nss_s1;
		logic nss_s2;
		logic nss_s3;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		spmsp_pin_out_type pins;
	} spmsp_pstate_type;

	// ==========================================================
	// slave serial clock domain state
	typedef struct packed {
		logic [7:0] sh;
		logic [2:0] cnt;
	} spmsp_sstate_type;

endpackage

// [sim/spmsp_far_end.sv]
/*
 * Far end of the serial link: a slave that answers the port's master, and a master that clocks the port's slave.
 * Assumes the bench resolves the pads and calls load, set_select and shift between frames.
 */
`timescale 1ns/1ps

module spmsp_far_end (
	input wire logic dut_sck,
	input wire logic dut_mosi,
	input wire logic dut_miso,
	output logic sck,
	output logic mosi,
	output logic miso,
	output logic nss,
	output logic [7:0] got
);
	logic [7:0] sh;

	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		nss = 1'b1;
		sh = 8'h00;
		got = 8'h00;
	end

	// ==========================================================
	// far slave, clock mode 0; filler bits flip so an idle line never repeats
	always @(posedge dut_sck) begin
		got <= {got[6:0], dut_mosi};
	end
	always @(negedge dut_sck) begin
		sh <= {sh[6:0], ~sh[7]};
	end
	assign miso = sh[7];

	task automatic load(input logic [7:0] b);
		sh = b;
	endtask

	task automatic set_select(input logic v);
		nss = v;
	endtask

	// ==========================================================
	// far master: 6 ns link clock, running only while shift runs, selected or not
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			mosi = tx[i];
			#3;
			rx = {rx[6:0], dut_miso};
			sck = 1'b1;
			#3;
			sck = 1'b0;
		end
		mosi = ~mosi;
	endtask
endmodule

// [sim/tb.sv]
/*
 * Directed bench of the serial port over APB, with the far-end model on the pins.
 * Assumes the package, the defines header and spmsp_far_end are compiled first.
 */
`timescale 1ns/1ps
`include "spmsp_defs.svh"

module tb;
	import spmsp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, miso_out, e, f_sck, f_mosi, f_miso, f_nss;
	logic [7:0] got, rx;
	spmsp_pin_in_type pin_in;
	spmsp_pin_out_type pin_out;
	int n_mismatch = 0, num_checks = 0;
	wire logic sck_line = pin_out.sck_oe_n ? f_sck : pin_out.sck_out;

	// ==========================================================
	// pads: whichever side enables a line drives it
	assign pin_in.mosi_in = pin_out.mosi_oe_n ? f_mosi : pin_out.mosi_out;
	assign pin_in.miso_in = pin_out.miso_oe_n ? f_miso : miso_out;
	assign pin_in.nss_in = pin_out.nss_oe_n ? f_nss : pin_out.nss_out;
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	spmsp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.sck_in(sck_line), .pin_in(pin_in), .pin_out(pin_out), .miso_out(miso_out));
	spmsp_far_end far (.dut_sck(sck_line), .dut_mosi(pin_in.mosi_in), .dut_miso(pin_in.miso_in), .sck(f_sck),
		.mosi(f_mosi), .miso(f_miso), .nss(f_nss), .got(got));

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// pins are registered, so two idle cycles follow each access
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic wait_done();
		int k;
		k = 0;
		do begin
			apb(1'b0, `SPMSP_STAT_OFF, 32'h0);
			k++;
		end while (r[7] !== 1'b1 && k < 40);
		apb(1'b0, `SPMSP_STAT_OFF, 32'h0);
		chk({31'h0, r[7]}, 32'h1);
		apb(1'b1, `SPMSP_STAT_OFF, 32'h80);
		apb(1'b0, `SPMSP_STAT_OFF, 32'h0);
		chk({31'h0, r[7]}, 32'h0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SPMSP_CTRL_OFF, 32'h0);
		chk(r, 32'h4);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk({28'h0, pin_out.mosi_oe_n, pin_out.miso_oe_n, pin_out.sck_oe_n, pin_out.nss_oe_n}, 32'hF);
		$display("test reset ended");
		far.load(8'h3C);
		apb(1'b1, `SPMSP_CTRL_OFF, 32'h3);
		apb(1'b1, `SPMSP_DATA_OFF, 32'hA5);
		chk({29'h0, pin_out.mosi_oe_n, pin_out.sck_oe_n, pin_out.nss_mapped}, 32'h0);
		wait_done();
		chk({24'h0, got}, 32'hA5);
		apb(1'b0, `SPMSP_DATA_OFF, 32'h0);
		chk(r, 32'h3C);
		$display("test master ended");
		// select output in modes 1x, level from the mode's low bit
		apb(1'b1, `SPMSP_CTRL_OFF, 32'hF);
		chk({29'h0, pin_out.nss_oe_n, pin_out.nss_out, pin_out.nss_mapped}, 32'h3);
		apb(1'b1, `SPMSP_CTRL_OFF, 32'hB);
		chk({29'h0, pin_out.nss_oe_n, pin_out.nss_out, pin_out.nss_mapped}, 32'h1);
		apb(1'b1, `SPMSP_CTRL_OFF, 32'h7);
		far.set_select(1'b0);
		repeat (8) @(posedge pclk);
		apb(1'b0, `SPMSP_CTRL_OFF, 32'h0);
		chk(r, 32'h4);
		apb(1'b0, `SPMSP_STAT_OFF, 32'h0);
		chk(r & 32'h20, 32'h20);
		apb(1'b1, `SPMSP_STAT_OFF, 32'h20);
		far.set_select(1'b1);
		$display("test select ended");
		apb(1'b1, `SPMSP_CTRL_OFF, 32'h5);
		apb(1'b1, `SPMSP_DATA_OFF, 32'h96);
		chk({31'h0, pin_out.miso_oe_n}, 32'h1);
		far.set_select(1'b0);
		#40;
		chk({31'h0, pin_out.miso_oe_n}, 32'h0);
		far.shift(8'h69, 8, rx);
		chk({24'h0, rx}, 32'h96);
		far.set_select(1'b1);
		wait_done();
		apb(1'b0, `SPMSP_DATA_OFF, 32'h0);
		chk(r, 32'h69);
		// a cut byte, then clocks while unselected, must not shift the count
		far.set_select(1'b0);
		#40;
		far.shift(8'hFF, 3, rx);
		far.set_select(1'b1);
		#40;
		far.shift(8'hFF, 5, rx);
		far.set_select(1'b0);
		#40;
		far.shift(8'hC3, 8, rx);
		far.set_select(1'b1);
		wait_done();
		apb(1'b0, `SPMSP_DATA_OFF, 32'h0);
		chk(r, 32'hC3);
		$display("test slave4 ended");
		apb(1'b1, `SPMSP_CTRL_OFF, 32'h1);
		chk({30'h0, pin_out.miso_oe_n, pin_out.nss_mapped}, 32'h0);
		apb(1'b1, `SPMSP_DATA_OFF, 32'h3A);
		far.shift(8'h5A, 8, rx);
		chk({24'h0, rx}, 32'h3A);
		wait_done();
		apb(1'b0, `SPMSP_DATA_OFF, 32'h0);
		chk(r, 32'h5A);
		apb(1'b1, `SPMSP_CTRL_OFF, 32'h0);
		chk({29'h0, pin_out.mosi_oe_n, pin_out.miso_oe_n, pin_out.sck_oe_n}, 32'h7);
		$display("test slave3 ended");
		results();
	end

	initial begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule
